// >>> logic/lts_defs.svh
// Register map, field positions, reset values and timing counts
`ifndef LTS_DEFS_SVH
`define LTS_DEFS_SVH
`define LTS_A_CMD 8'h00
`define LTS_A_CFG 8'h04
`define LTS_A_CNT 8'h08
`define LTS_A_LEN 8'h0C
`define LTS_A_IDX 8'h10
`define LTS_A_VOLT 8'h14
`define LTS_A_CURR 8'h18
`define LTS_A_DWEL 8'h1C
`define LTS_A_STAT 8'h20
`define LTS_A_LVL 8'h24
`define LTS_A_IMM 8'h28
`define LTS_A_MASK 8'h2C
`define LTS_A_RESP 8'h30
`define LTS_C_INIT 0
`define LTS_C_ABORT 1
`define LTS_C_TRIG 2
`define LTS_C_RST 3
`define LTS_C_RCL 4
`define LTS_C_SAV 5
`define LTS_C_OPC 6
`define LTS_C_OPCQ 7
`define LTS_C_WAI 8
`define LTS_C_CLS 9
`define LTS_CNT_INF 31
`define LTS_CFG_RST 16'h0000
`define LTS_CNT_RST 16'h0001
`define LTS_NPTS 5'h14
`define LTS_LINK_SUM 2'h0
`define LTS_EV_RTG 2'h0
`define LTS_EV_STS 2'h1
`define LTS_EV_STC 2'h2
`define LTS_EV_LSC 2'h3
`define LTS_CLK_NS 25
`define LTS_TRIG_PULSE_NS 20000
`define LTS_TRIG_PULSE_CYC ((`LTS_TRIG_PULSE_NS+`LTS_CLK_NS-1)/`LTS_CLK_NS)
`define LTS_DWELL_UNIT_NS 1000000000
`define LTS_DWELL_UNIT_CYC (`LTS_DWELL_UNIT_NS/`LTS_CLK_NS)
`endif

// >>> logic/lts_pkg.sv
// Types shared by the list and trigger sequencer
package lts_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_DWELL} lts_state_t;
  typedef struct packed {
    logic [4:0] rsvd;
    logic curr_list;
    logic volt_list;
    logic out_en;
    logic rs_en;
    logic [1:0] fault_link;
    logic [1:0] ttl_src;
    logic ttl_en;
    logic src_ext;
    logic step_auto;
  } lts_cfg_t;
  typedef struct packed {
    logic [15:0] curr;
    logic [15:0] volt;
  } lts_level_t;
  typedef struct packed {
    logic [7:0] evt;
    logic [7:0] oper;
    logic [7:0] ques;
  } lts_mask_t;
endpackage

// >>> logic/lts_top.sv
// List sequencer, trigger lines, fault and shutdown logic, completion
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "lts_defs.svh"

module lts_pulse #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic core_clk, // Clock
  input wire logic rst,      // Async reset
  input wire logic fire,     // Start or restart pulse
  output logic active        // Pulse level
);
  localparam int CW = $clog2(WIDTH + 1);
  logic [CW-1:0] cnt_q;
  // A new fire mid-pulse reloads the count, so pulses never merge short
  always_ff @(posedge core_clk or posedge rst) begin // [R25]
    if (rst) begin
      cnt_q <= '0;
      active <= 1'b0;
    end else if (fire) begin
      cnt_q <= CW'(WIDTH - 1);
      active <= 1'b1;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end else begin
      active <= 1'b0;
    end
  end
endmodule

// Function
// [R1] External trigger counts on falling edge only
// [R2] Trigger output is one 20 us low pulse
// [R3] Host enables trigger output and picks source
// [R4] Twenty voltage, current and dwell entries stored
// [R5] Points applied in written order
// [R6] Single-point list repeats to other list length
// [R7] Single dwell entry applies to every point
// [R8] Dwell entries are seconds
// [R9] Abort, list write, reset, recall stop list
// [R10] Immediate level write overrides current interval
// [R11] Repeat count integer or infinite
// [R12] Count saved, recalled, reset to one
// [R13] No list output before a trigger
// [R14] Auto mode runs whole list from one trigger
// [R15] Step mode rearms after each dwell
// [R16] Software trigger advances when not dwelling
// [R17] Active-low fault output from selectable link
// [R18] Summary link ORs masked status; reset selects it
// [R19] Remote shutdown turns output off, flags status
// [R20] Wait holds commands until operations complete
// [R21] Completion query queues a one when done
// [R22] Complete bit only when idle, nothing pending
// [R23] Dwelling ignores triggers; only abort exits
// [R24] Initiate moves idle to armed
// [R25] Pulse counts clocks, restarts on refire
module lts_top #(
  parameter int unsigned DWELL_CYC = `LTS_DWELL_UNIT_CYC
) (
  input wire logic core_clk,           // 40 MHz clock
  input wire logic rst,                // Async reset, high
  input wire logic [7:0] reg_addr,     // Register byte address
  input wire logic [31:0] reg_wdata,   // Write data
  input wire logic reg_wr,             // Write strobe
  input wire logic reg_rd,             // Read strobe
  output logic [31:0] reg_rdata,       // Read data, cycle after strobe
  input wire logic trig_in_n,          // Shared trigger input pin
  output logic trig_out_n,             // Shared trigger output pin
  input wire logic shutdown_n,         // Shutdown input jack
  output logic fault_n,                // Fault jack output
  input wire logic [6:0] ques_in,      // Other questionable bits
  input wire logic [7:0] evt_in,       // Event status bits
  input wire logic ext_pending,        // Other subsystem busy
  output logic cmd_hold,               // Stall later commands
  output logic output_on,              // Module output enabled
  output lts_pkg::lts_level_t level_out // Applied set-points
);
  localparam int unsigned PW = `LTS_TRIG_PULSE_CYC;
  lts_pkg::lts_state_t state_q;
  lts_pkg::lts_cfg_t cfg_q;
  lts_pkg::lts_mask_t mask_q;
  logic [15:0] volt_mem [0:19];
  logic [15:0] curr_mem [0:19];
  logic [15:0] dwel_mem [0:19];
  logic [4:0] vl_q, cl_q, dl_q, widx_q, idx_q, npts, vi, ci, di;
  logic [15:0] cnt_q, pass_q, sec_q, save_cnt_q;
  logic inf_q, save_inf_q, done_q, last_q;
  logic [31:0] cyc_q;
  logic [2:0] trig_s_q, sd_s_q;
  logic trig_lvl_q, sd_lvl_q, fall;
  logic opc_pend_q, opc_bit_q, opcq_pend_q, resp_q, wai_q, fault_q;
  logic [9:0] c;
  logic wr_cmd, wr_imm, list_cmd, abort, trig_ev, go, expire, apply;
  logic last_pt, complete, rs_act, summary, trig_act, flt_act;
  logic rtg, sts, stc, lsc, ttl_ev, flt_ev, ttl_fire;
  logic [7:0] ques, oper;

  function automatic logic [4:0] clamp(input logic [4:0] v);
    clamp = (v > `LTS_NPTS) ? `LTS_NPTS : v;
  endfunction

  assign wr_cmd = reg_wr && reg_addr == `LTS_A_CMD;
  assign c = wr_cmd ? reg_wdata[9:0] : 10'h000;
  assign wr_imm = reg_wr && reg_addr == `LTS_A_IMM;
  assign list_cmd = reg_wr && (reg_addr == `LTS_A_CNT ||
    reg_addr == `LTS_A_LEN || reg_addr == `LTS_A_VOLT ||
    reg_addr == `LTS_A_CURR || reg_addr == `LTS_A_DWEL);
  assign abort = c[`LTS_C_ABORT] || list_cmd || c[`LTS_C_RST] ||
    c[`LTS_C_RCL]; // [R9]

  // Pins are asynchronous: 3 stages, a level is accepted once 2 and 3 agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trig_s_q <= 3'h7;
      sd_s_q <= 3'h7;
      trig_lvl_q <= 1'b1;
      sd_lvl_q <= 1'b1;
    end else begin
      trig_s_q <= {trig_s_q[1:0], trig_in_n};
      sd_s_q <= {sd_s_q[1:0], shutdown_n};
      if (trig_s_q[1] == trig_s_q[2]) trig_lvl_q <= trig_s_q[2];
      if (sd_s_q[1] == sd_s_q[2]) sd_lvl_q <= sd_s_q[2];
    end
  end
  assign fall = trig_lvl_q && trig_s_q[1] == trig_s_q[2] &&
    !trig_s_q[2]; // [R1]

  // Configuration, count, masks and list storage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= `LTS_CFG_RST;
      mask_q <= '0;
      cnt_q <= `LTS_CNT_RST;
      inf_q <= 1'b0;
      save_cnt_q <= `LTS_CNT_RST;
      save_inf_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `LTS_A_CFG)
        cfg_q <= {5'h00, reg_wdata[10:0]};
      if (reg_wr && reg_addr == `LTS_A_MASK)
        mask_q <= reg_wdata[23:0];
      if (reg_wr && reg_addr == `LTS_A_CNT) begin
        cnt_q <= reg_wdata[15:0];
        inf_q <= reg_wdata[`LTS_CNT_INF]; // [R11]
      end
      if (c[`LTS_C_SAV]) begin
        save_cnt_q <= cnt_q;
        save_inf_q <= inf_q;
      end
      if (c[`LTS_C_RCL]) begin
        cnt_q <= save_cnt_q; // [R12]
        inf_q <= save_inf_q;
      end
      if (c[`LTS_C_RST]) begin
        cnt_q <= `LTS_CNT_RST; // [R12]
        inf_q <= 1'b0;
        cfg_q.fault_link <= `LTS_LINK_SUM; // [R18]
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin // [R4]
    if (rst) begin
      vl_q <= 5'h00;
      cl_q <= 5'h00;
      dl_q <= 5'h00;
      widx_q <= 5'h00;
      for (int i = 0; i < 20; i++) begin
        volt_mem[i] <= 16'h0000;
        curr_mem[i] <= 16'h0000;
        dwel_mem[i] <= 16'h0000;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `LTS_A_LEN: begin
          vl_q <= clamp(reg_wdata[4:0]);
          cl_q <= clamp(reg_wdata[12:8]);
          dl_q <= clamp(reg_wdata[20:16]);
        end
        `LTS_A_IDX: widx_q <= (reg_wdata[4:0] >= `LTS_NPTS) ?
          5'(`LTS_NPTS - 5'h01) : reg_wdata[4:0];
        `LTS_A_VOLT: volt_mem[widx_q] <= reg_wdata[15:0];
        `LTS_A_CURR: curr_mem[widx_q] <= reg_wdata[15:0];
        `LTS_A_DWEL: dwel_mem[widx_q] <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // An empty list is run as one point rather than stalling the sequencer
  always_comb begin // [R6]
    if (cfg_q.volt_list && cfg_q.curr_list)
      npts = (vl_q == 5'h01) ? cl_q : vl_q;
    else if (cfg_q.curr_list)
      npts = cl_q;
    else
      npts = vl_q;
    if (npts == 5'h00) npts = 5'h01;
  end
  assign vi = (vl_q == 5'h01) ? 5'h00 : idx_q; // [R6]
  assign ci = (cl_q == 5'h01) ? 5'h00 : idx_q; // [R6]
  assign di = (dl_q == 5'h01) ? 5'h00 : idx_q; // [R7]
  assign last_pt = 5'(idx_q + 5'h01) >= npts;

  assign trig_ev = (cfg_q.src_ext && fall) || c[`LTS_C_TRIG]; // [R16]
  assign go = state_q == lts_pkg::ST_ARMED && trig_ev; // [R13]
  assign expire = state_q == lts_pkg::ST_DWELL && sec_q == 16'h0000 &&
    cyc_q == 32'h0000_0000;
  assign apply = !abort && (go ||
    (expire && cfg_q.step_auto && !done_q)); // [R14]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= lts_pkg::ST_IDLE;
      idx_q <= 5'h00;
      pass_q <= 16'h0000;
      sec_q <= 16'h0000;
      cyc_q <= 32'h0000_0000;
      done_q <= 1'b0;
      last_q <= 1'b0;
    end else if (abort) begin
      state_q <= lts_pkg::ST_IDLE; // [R9]
      idx_q <= 5'h00;
      pass_q <= 16'h0000;
    end else begin
      case (state_q)
        lts_pkg::ST_IDLE:
          if (c[`LTS_C_INIT]) state_q <= lts_pkg::ST_ARMED; // [R24]
        lts_pkg::ST_ARMED: ;
        lts_pkg::ST_DWELL:
          // Triggers are not looked at here at all
          if (expire) begin // [R23]
            state_q <= done_q ? lts_pkg::ST_IDLE :
              lts_pkg::ST_ARMED; // [R15]
          end else if (cyc_q != 32'h0000_0000) begin
            cyc_q <= cyc_q - 32'h0000_0001; // [R8]
          end else begin
            sec_q <= sec_q - 16'h0001;
            cyc_q <= DWELL_CYC - 1;
          end
        default: state_q <= lts_pkg::ST_IDLE;
      endcase
      if (apply) begin
        state_q <= lts_pkg::ST_DWELL;
        sec_q <= dwel_mem[di]; // [R8]
        // Start at zero so d seconds last d*DWELL_CYC+1 cycles, not d+1
        cyc_q <= 32'h0000_0000; // [R8]
        last_q <= last_pt;
        idx_q <= last_pt ? 5'h00 : 5'(idx_q + 5'h01); // [R5]
        if (last_pt) begin
          // Count zero behaves as one pass
          done_q <= !inf_q &&
            16'(pass_q + 16'h0001) >= cnt_q; // [R11]
          pass_q <= (!inf_q && 16'(pass_q + 16'h0001) >= cnt_q) ?
            16'h0000 : 16'(pass_q + 16'h0001);
        end else begin
          done_q <= 1'b0;
        end
      end
    end
  end

  // Later writes in the same interval win; the next point replaces the fields whose list is enabled
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      level_out <= '0;
    end else begin
      if (apply && cfg_q.volt_list) level_out.volt <= volt_mem[vi];
      if (apply && cfg_q.curr_list) level_out.curr <= curr_mem[ci];
      if (wr_imm) level_out <= reg_wdata; // [R10]
    end
  end

  assign rtg = go;
  assign sts = apply;
  assign stc = expire && !abort;
  assign lsc = stc && last_q;
  always_comb begin
    case (cfg_q.ttl_src)
      `LTS_EV_RTG: ttl_ev = rtg;
      `LTS_EV_STS: ttl_ev = sts;
      `LTS_EV_STC: ttl_ev = stc;
      default: ttl_ev = lsc;
    endcase
    case (cfg_q.fault_link)
      2'h1: flt_ev = rtg;
      2'h2: flt_ev = stc;
      2'h3: flt_ev = lsc;
      default: flt_ev = 1'b0;
    endcase
  end
  assign ttl_fire = cfg_q.ttl_en && ttl_ev; // [R3]

  lts_pulse #(.WIDTH(PW)) u_trig_pulse (
    .core_clk(core_clk),
    .rst(rst),
    .fire(ttl_fire),
    .active(trig_act)
  );
  lts_pulse #(.WIDTH(PW)) u_fault_pulse (
    .core_clk(core_clk),
    .rst(rst),
    .fire(flt_ev),
    .active(flt_act)
  );
  assign trig_out_n = ~trig_act; // [R2]

  assign rs_act = cfg_q.rs_en && !sd_lvl_q; // [R19]
  assign ques = {ques_in, rs_act}; // [R19]
  assign oper = {6'h00, state_q == lts_pkg::ST_ARMED,
    state_q == lts_pkg::ST_DWELL};
  assign summary = |(ques & mask_q.ques) | |(oper & mask_q.oper) |
    |(evt_in & mask_q.evt); // [R18]
  assign complete = state_q == lts_pkg::ST_IDLE && !ext_pending; // [R22]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_q <= 1'b0;
      output_on <= 1'b0;
    end else begin
      fault_q <= (cfg_q.fault_link == `LTS_LINK_SUM) ? summary :
        flt_act; // [R17]
      output_on <= cfg_q.out_en && !rs_act; // [R19]
    end
  end
  assign fault_n = ~fault_q; // [R17]

  // Every set below beats its clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      opc_pend_q <= 1'b0;
      opc_bit_q <= 1'b0;
      opcq_pend_q <= 1'b0;
      resp_q <= 1'b0;
      wai_q <= 1'b0;
    end else begin
      opc_pend_q <= c[`LTS_C_OPC] || (opc_pend_q && !complete);
      opc_bit_q <= (opc_pend_q && complete) ||
        (opc_bit_q && !c[`LTS_C_CLS]); // [R22]
      opcq_pend_q <= c[`LTS_C_OPCQ] || (opcq_pend_q && !complete);
      resp_q <= (opcq_pend_q && complete) || (resp_q &&
        !(reg_rd && reg_addr == `LTS_A_RESP)); // [R21]
      // Hangs for good if the list never finishes; abort frees it
      wai_q <= c[`LTS_C_WAI] || (wai_q && !complete); // [R20]
    end
  end
  assign cmd_hold = wai_q; // [R20]

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      case (reg_addr)
        `LTS_A_CFG: reg_rdata <= {16'h0000, cfg_q};
        `LTS_A_CNT: reg_rdata <= {inf_q, 15'h0000, cnt_q};
        `LTS_A_LEN: reg_rdata <= {11'h000, dl_q, 3'h0, cl_q, 3'h0, vl_q};
        `LTS_A_IDX: reg_rdata <= {27'h0000000, widx_q};
        `LTS_A_VOLT: reg_rdata <= {16'h0000, volt_mem[widx_q]};
        `LTS_A_CURR: reg_rdata <= {16'h0000, curr_mem[widx_q]};
        `LTS_A_DWEL: reg_rdata <= {16'h0000, dwel_mem[widx_q]};
        `LTS_A_STAT: reg_rdata <= {15'h0000, complete, 3'h0, idx_q,
          1'b0, output_on, rs_act, opc_bit_q, oper[1], oper[0],
          state_q};
        `LTS_A_LVL: reg_rdata <= level_out;
        `LTS_A_MASK: reg_rdata <= {8'h00, mask_q};
        `LTS_A_RESP: reg_rdata <= {31'h00000000, resp_q};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  logic [9:0] tp_len_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) tp_len_q <= 10'h000;
    else if (ttl_fire) tp_len_q <= 10'h000;
    else if (trig_act) tp_len_q <= 10'(tp_len_q + 10'h001);
    else tp_len_q <= 10'h000;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_ext_edge_only: assert property ( // [R1]
    state_q == lts_pkg::ST_ARMED && !fall && !c[`LTS_C_TRIG]
    |=> state_q != lts_pkg::ST_DWELL) else $error("start without edge");
  a_pulse_width: assert property ($fell(trig_act) |-> // [R2]
    tp_len_q == 10'd800) else $error("trigger pulse width wrong");
  a_index_range: assert property (idx_q < `LTS_NPTS && // [R4]
    widx_q < `LTS_NPTS) else $error("list index out of range");
  a_point_order: assert property (apply |=> idx_q == // [R5]
    ($past(last_pt) ? 5'h00 : 5'($past(idx_q) + 5'h01)))
    else $error("point order broken");
  a_single_volt: assert property (apply && vl_q == 5'h01 && // [R6]
    cfg_q.volt_list && !wr_imm |=> level_out.volt == volt_mem[0])
    else $error("single point not repeated");
  a_single_dwell: assert property (apply && dl_q == 5'h01 |=> // [R7]
    sec_q == dwel_mem[0]) else $error("single dwell not shared");
  a_abort_idle: assert property (abort |=> // [R9]
    state_q == lts_pkg::ST_IDLE && idx_q == 5'h00)
    else $error("abort did not stop list");
  a_imm_level: assert property (wr_imm |=> // [R10]
    level_out == $past(reg_wdata)) else $error("level override lost");
  a_reset_count: assert property (c[`LTS_C_RST] |=> // [R12]
    cnt_q == 16'h0001 && !inf_q) else $error("count not reset to 1");
  a_idle_no_run: assert property (state_q == lts_pkg::ST_IDLE |=> // [R13]
    state_q != lts_pkg::ST_DWELL) else $error("list ran untriggered");
  a_step_rearm: assert property (expire && !cfg_q.step_auto && // [R15]
    !done_q && !abort |=> state_q == lts_pkg::ST_ARMED)
    else $error("step mode did not rearm");
  a_dwell_hold: assert property (state_q == lts_pkg::ST_DWELL && // [R23]
    !expire && !abort |=> state_q == lts_pkg::ST_DWELL &&
    $stable(idx_q)) else $error("dwell disturbed");
  a_shutdown_off: assert property (rs_act |=> !output_on) // [R19]
    else $error("shutdown ignored");
  a_opc_idle: assert property ($rose(opc_bit_q) |-> // [R22]
    $past(state_q) == lts_pkg::ST_IDLE && !$past(ext_pending))
    else $error("complete while busy");
  c_auto_step: cover property (apply && cfg_q.step_auto && !go);
  c_list_done: cover property (expire && done_q);
  c_trig_fire: cover property (ttl_fire);
  c_shutdown: cover property (rs_act && fault_q);
endmodule

// >>> tb/lts_far_end.sv
// Model of the trigger source, trigger receiver and shutdown jack
`timescale 1ns/1ps

module lts_far_end (
  input wire logic core_clk,   // Module clock
  input wire logic trig_out_n, // Trigger pulse from the module
  output logic trig_in_n,      // Shared trigger line into the module
  output logic shutdown_n      // Shutdown jack level
);
  int low_len;
  int pulses;
  int run;

  // Both lines idle high, as their pull-ups would leave them
  initial begin
    trig_in_n = 1'b1;
    shutdown_n = 1'b1;
    low_len = 0;
    pulses = 0;
    run = 0;
  end

  // Receiver times each low pulse in module clocks
  always @(posedge core_clk) begin
    if (!trig_out_n) begin
      run <= run + 1;
    end else if (run != 0) begin
      low_len <= run;
      pulses <= pulses + 1;
      run <= 0;
    end
  end

  // Long low hold puts the rising edge well after the falling one
  task automatic ext_trigger(input int hold);
    @(posedge core_clk);
    trig_in_n <= 1'b0;
    repeat (hold) @(posedge core_clk);
    trig_in_n <= 1'b1;
  endtask

  task automatic set_shutdown(input logic lvl);
    @(posedge core_clk);
    shutdown_n <= lvl;
  endtask
endmodule

// >>> tb/testbench.sv
// Register-level tests of the list and trigger sequencer
`timescale 1ns/1ps
`include "lts_defs.svh"

module testbench;
  logic core_clk;
  logic rst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic trig_in_n;
  logic trig_out_n;
  logic shutdown_n;
  logic fault_n;
  logic [6:0] ques_in;
  logic [7:0] evt_in;
  logic ext_pending;
  logic cmd_hold;
  logic output_on;
  lts_pkg::lts_level_t level_out;
  int n_fail;
  int comparisons;
  int n;
  logic [31:0] d;
  logic [31:0] pt [3];
  logic [7:0] ab_a [4];
  logic [31:0] ab_d [4];

  lts_top #(.DWELL_CYC(20)) dut (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trig_in_n(trig_in_n),
    .trig_out_n(trig_out_n), .shutdown_n(shutdown_n), .fault_n(fault_n),
    .ques_in(ques_in), .evt_in(evt_in), .ext_pending(ext_pending),
    .cmd_hold(cmd_hold), .output_on(output_on), .level_out(level_out)
  );

  lts_far_end far (
    .core_clk(core_clk), .trig_out_n(trig_out_n),
    .trig_in_n(trig_in_n), .shutdown_n(shutdown_n)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic stop_test();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Counts edges until the expected level shows; a miss ends the run
  task automatic wait_level(input logic [31:0] e, input int lim,
                            output int cnt);
    cnt = 0;
    #1;
    while (level_out !== e) begin
      if (cnt >= lim) begin
        chk("level_out", e, level_out);
        stop_test();
      end
      @(posedge core_clk);
      #1;
      cnt++;
    end
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    n_fail++;
    stop_test();
  end

  initial begin
    n_fail = 0;
    comparisons = 0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ques_in = 7'h00;
    evt_in = 8'h00;
    ext_pending = 1'b0;
    for (int i = 0; i < 3; i++) pt[i] = {16'h0A00, 16'h0100 + 16'(i)};
    ab_a = '{`LTS_A_CMD, `LTS_A_CMD, `LTS_A_CMD, `LTS_A_LEN};
    ab_d = '{32'h0000_0002, 32'h0000_0008, 32'h0000_0010, 32'h0001_0103};
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd(`LTS_A_STAT, d); chk("stat", 32'h0001_0000, d);
    rd(`LTS_A_CNT, d); chk("count", 32'h0000_0001, d);
    rd(8'h3C, d); chk("unmapped", 32'h0000_0000, d);
    chk("fault_n", 32'h1, 32'(fault_n));
    // Three voltage points, one current point, one dwell entry
    for (int i = 0; i < 3; i++) begin
      wr(`LTS_A_IDX, 32'(i));
      wr(`LTS_A_VOLT, {16'h0000, pt[i][15:0]});
    end
    wr(`LTS_A_IDX, 32'h0);
    wr(`LTS_A_CURR, 32'h0000_0A00);
    wr(`LTS_A_DWEL, 32'h0000_0001);
    wr(`LTS_A_LEN, 32'h0001_0103);
    wr(`LTS_A_CFG, 32'h0000_0705);
    wr(`LTS_A_CNT, 32'h0000_0002);
    repeat (30) @(posedge core_clk);
    chk("level idle", 32'h0, level_out);
    wr(`LTS_A_CMD, 32'h0000_0001);
    rd(`LTS_A_STAT, d); chk("armed", 32'h1, {30'h0, d[1:0]});
    chk("complete armed", 32'h0, 32'(d[16]));
    wr(`LTS_A_CMD, 32'h0000_0004);
    // Auto pacing: each point holds 1*20+1 cycles, two passes
    for (int k = 0; k < 6; k++) begin
      wait_level(pt[k % 3], 30, n);
      chk("dwell cycles", (k == 0) ? 0 : 21, 32'(n));
    end
    repeat (900) @(posedge core_clk);
    rd(`LTS_A_STAT, d); chk("done idle", 32'h0, {30'h0, d[1:0]});
    chk("pulse count", 32'h1, 32'(far.pulses));
    chk("pulse len", `LTS_TRIG_PULSE_CYC, 32'(far.low_len));
    // Step pacing, first step from the external line, second from a software trigger
    wr(`LTS_A_CFG, 32'h0000_0702);
    wr(`LTS_A_CNT, 32'h0000_0001);
    wr(`LTS_A_CMD, 32'h0000_0001);
    fork
      far.ext_trigger(60);
    join_none
    wait_level(pt[0], 12, n);
    wr(`LTS_A_CMD, 32'h0000_0004);
    repeat (70) @(posedge core_clk);
    chk("step hold", pt[0], level_out);
    rd(`LTS_A_STAT, d); chk("rearmed", 32'h1, {30'h0, d[1:0]});
    wr(`LTS_A_CMD, 32'h0000_0004);
    #1 chk("soft step", pt[1], level_out);
    // Immediate write overrides only the running interval
    wr(`LTS_A_CMD, 32'h0000_0002);
    wr(`LTS_A_CFG, 32'h0000_0701);
    wr(`LTS_A_CMD, 32'h0000_0001);
    wr(`LTS_A_CMD, 32'h0000_0004);
    wr(`LTS_A_IMM, 32'h1234_5678);
    #1 chk("immediate", 32'h1234_5678, level_out);
    wait_level(pt[1], 25, n);
    // Abort, reset, recall and a length write each return a running list to idle
    for (int k = 0; k < 4; k++) begin
      wr(`LTS_A_CFG, 32'h0000_0701);
      wr(`LTS_A_CMD, 32'h0000_0001);
      wr(`LTS_A_CMD, 32'h0000_0004);
      wr(ab_a[k], ab_d[k]);
      rd(`LTS_A_STAT, d); chk("aborted", 32'h0, {30'h0, d[1:0]});
    end
    // Endless repeat still dwelling after three passes
    wr(`LTS_A_CFG, 32'h0000_0701);
    wr(`LTS_A_CNT, 32'h8000_0000);
    wr(`LTS_A_CMD, 32'h0000_0001);
    wr(`LTS_A_CMD, 32'h0000_0004);
    repeat (200) @(posedge core_clk);
    rd(`LTS_A_STAT, d); chk("endless", 32'h2, {30'h0, d[1:0]});
    wr(`LTS_A_CMD, 32'h0000_0002);
    // Count saved, recalled and reset
    wr(`LTS_A_CNT, 32'h0000_0005);
    wr(`LTS_A_CMD, 32'h0000_0020);
    wr(`LTS_A_CNT, 32'h0000_0007);
    wr(`LTS_A_CMD, 32'h0000_0010);
    rd(`LTS_A_CNT, d); chk("recalled", 32'h0000_0005, d);
    wr(`LTS_A_CMD, 32'h0000_0008);
    rd(`LTS_A_CNT, d); chk("reset count", 32'h0000_0001, d);
    // Shutdown jack through the summary link to the fault jack
    wr(`LTS_A_CFG, 32'h0000_0180);
    wr(`LTS_A_MASK, 32'h0000_0001);
    #1 chk("out on", 32'h1, 32'(output_on));
    far.set_shutdown(1'b0);
    repeat (6) @(posedge core_clk);
    #1 chk("out off", 32'h0, 32'(output_on));
    chk("fault low", 32'h0, 32'(fault_n));
    rd(`LTS_A_STAT, d); chk("rs flag", 32'h1, 32'(d[5]));
    far.set_shutdown(1'b1);
    repeat (6) @(posedge core_clk);
    #1 chk("out back", 32'h1, 32'(output_on));
    // Completion held off by another subsystem
    @(posedge core_clk);
    ext_pending <= 1'b1;
    wr(`LTS_A_CMD, 32'h0000_0080);
    wr(`LTS_A_CMD, 32'h0000_0100);
    @(posedge core_clk);
    #1 chk("hold", 32'h1, 32'(cmd_hold));
    rd(`LTS_A_RESP, d); chk("resp early", 32'h0, d);
    wr(`LTS_A_CMD, 32'h0000_0040);
    rd(`LTS_A_STAT, d); chk("opc early", 32'h0, 32'(d[4]));
    ext_pending <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk("released", 32'h0, 32'(cmd_hold));
    rd(`LTS_A_RESP, d); chk("resp", 32'h1, d);
    rd(`LTS_A_STAT, d); chk("opc", 32'h1, 32'(d[4]));
    stop_test();
  end
endmodule
